// file: verilog/pmb_pkg.sv
// Constants, types and helpers shared by the power-management interrupt mask bank.
// Assumes a single 100 MHz clock and a synchronous active-low reset in every user.
// Operation
// - Mask 0 lets event flag; 1 suppresses.
// - First top mask bit 7 gates power-good.
// - Masks never alter raw status bits.
// - First top mask bit gates sync-clock flag.
// - First top mask bit 2 gates thermal warning.
// - First top mask bit 0 gates sample-ready.
// - Second mask bit 0 gates reset; 7:1 reserved.
// - Host writes to reset mask bit do nothing.
// - Converter mask bit 7 gates output-invalid edge.
// - Converter mask bit 6 gates output-valid edge.
package pmb_pkg;

  // Register offsets on the serial port.
  localparam logic [7:0] TOP_MASK_ONE_OFS = 8'h20;
  localparam logic [7:0] TOP_MASK_TWO_OFS = 8'h21;
  localparam logic [7:0] CONV_MASK_OFS    = 8'h22;

  // Field positions inside the mask registers.
  localparam int unsigned PG_MASK_BIT      = 7;
  localparam int unsigned SYNC_MASK_BIT    = 4;
  localparam int unsigned THERM_MASK_BIT   = 2;
  localparam int unsigned SAMPLE_MASK_BIT  = 0;
  localparam int unsigned REGRST_MASK_BIT  = 0;
  localparam int unsigned CONV_FALL_BIT    = 7;
  localparam int unsigned CONV_RISE_BIT    = 6;

  // Values in reset, fields taken from OTP, and host-writable fields.
  localparam logic [7:0] MASK_RESET         = 8'h00;
  localparam logic [7:0] TOP_ONE_OTP_FIELDS = 8'h95;
  localparam logic [7:0] TOP_TWO_OTP_FIELDS = 8'h01;
  localparam logic [7:0] CONV_OTP_FIELDS    = 8'hDD;
  localparam logic [7:0] TOP_ONE_WR_FIELDS  = 8'hFF;
  localparam logic [7:0] TOP_TWO_WR_FIELDS  = 8'hFE;
  localparam logic [7:0] CONV_WR_FIELDS     = 8'hDD;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // Flag vector layout.
  localparam int unsigned FLAG_W     = 6;
  localparam int unsigned FLG_PG     = 0;
  localparam int unsigned FLG_SYNC   = 1;
  localparam int unsigned FLG_THERM  = 2;
  localparam int unsigned FLG_SAMPLE = 3;
  localparam int unsigned FLG_REGRST = 4;
  localparam int unsigned FLG_CONV   = 5;

  // Serial port constants; the device address value is arbitrary.
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h3A;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam logic [3:0] LAST_READ_BIT    = 4'h7;
  localparam logic [3:0] BIT_CNT_RESET    = 4'h0;
  localparam logic [7:0] PTR_RESET        = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } pmb_i2c_state_t;

  function automatic logic pmb_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction : pmb_hit

endpackage : pmb_pkg

// file: verilog/pmb_reg_if.sv
// Register access and mask distribution between the serial port, mask bank and flags.
// Assumes all users sit on the same clock.
`timescale 1ns/1ps
interface pmb_reg_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] mask_top_one;
  logic [7:0] mask_top_two;
  logic [7:0] mask_conv;
  logic       masks_valid;

  modport bus (output wr_en, output addr, output wdata, input rdata);
  modport regs (input wr_en, input addr, input wdata, output rdata,
                output mask_top_one, output mask_top_two, output mask_conv,
                output masks_valid);
  modport flags (input mask_top_one, input mask_top_two, input mask_conv,
                 input masks_valid);
endinterface : pmb_reg_if

// file: verilog/pmb_mask_regs.sv
// The three mask registers, their OTP load after reset and their read decode.
// Assumes OTP values are stable from reset release onward.
`timescale 1ns/1ps
module pmb_mask_regs
  import pmb_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_b,
  // OTP defaults.
  input  wire logic [7:0] otp_top_mask_one,
  input  wire logic [7:0] otp_top_mask_two,
  input  wire logic [7:0] otp_conv_mask,
  // Register side.
  pmb_reg_if.regs         rif
);

  logic [7:0] top_one_reg;
  logic [7:0] top_two_reg;
  logic [7:0] conv_reg;
  logic       loaded_reg;
  logic [7:0] top_one_next;
  logic [7:0] top_two_next;
  logic [7:0] conv_next;

  wire hit_one  = pmb_hit(rif.addr, TOP_MASK_ONE_OFS);
  wire hit_two  = pmb_hit(rif.addr, TOP_MASK_TWO_OFS);
  wire hit_conv = pmb_hit(rif.addr, CONV_MASK_OFS);

  // The first cycle after reset loads OTP and wins over any host write.
  always_comb begin
    top_one_next = top_one_reg;
    top_two_next = top_two_reg;
    conv_next    = conv_reg;
    if (!loaded_reg) begin
      top_one_next = otp_top_mask_one & TOP_ONE_OTP_FIELDS;
      top_two_next = otp_top_mask_two & TOP_TWO_OTP_FIELDS;
      conv_next    = otp_conv_mask & CONV_OTP_FIELDS;
    end else if (rif.wr_en) begin
      if (hit_one) begin
        top_one_next = rif.wdata & TOP_ONE_WR_FIELDS;
      end
      if (hit_two) begin
        top_two_next = (top_two_reg & ~TOP_TWO_WR_FIELDS)
                     | (rif.wdata & TOP_TWO_WR_FIELDS);
      end
      if (hit_conv) begin
        conv_next = rif.wdata & CONV_WR_FIELDS;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      top_one_reg <= MASK_RESET;
      top_two_reg <= MASK_RESET;
      conv_reg    <= MASK_RESET;
      loaded_reg  <= 1'b0;
    end else begin
      top_one_reg <= top_one_next;
      top_two_reg <= top_two_next;
      conv_reg    <= conv_next;
      loaded_reg  <= 1'b1;
    end
  end

  assign rif.rdata = hit_one  ? top_one_reg :
                     hit_two  ? top_two_reg :
                     hit_conv ? conv_reg    : READ_UNMAPPED;
  assign rif.mask_top_one = top_one_reg;
  assign rif.mask_top_two = top_two_reg;
  assign rif.mask_conv    = conv_reg;
  assign rif.masks_valid  = loaded_reg;

endmodule : pmb_mask_regs

// file: verilog/pmb_event_flags.sv
// Sticky interrupt flags gated by the masks, and the combined interrupt output.
// Assumes event pulses and clears come from logic on the same clock.
`timescale 1ns/1ps
module pmb_event_flags
  import pmb_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Masks.
  pmb_reg_if.flags               rif,
  // Events and clears.
  input  wire logic              power_good_event,
  input  wire logic              sync_clk_event,
  input  wire logic              thermal_warning_event,
  input  wire logic              current_sample_ready_event,
  input  wire logic              reg_reset_event,
  input  wire logic              conv_one_pg_rise_event,
  input  wire logic              conv_one_pg_fall_event,
  input  wire logic [FLAG_W-1:0] flag_clear,
  // Results.
  output logic      [FLAG_W-1:0] flags,
  output logic                   irq_active
);

  logic [FLAG_W-1:0] flag_reg;
  logic [FLAG_W-1:0] flag_next;
  logic              irq_reg;
  logic              irq_next;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] enabled;

  wire conv_rise_ok = ~rif.mask_conv[CONV_RISE_BIT];
  wire conv_fall_ok = ~rif.mask_conv[CONV_FALL_BIT];

  // A mask bit of zero lets the event through.
  assign enabled[FLG_PG]     = ~rif.mask_top_one[PG_MASK_BIT];
  assign enabled[FLG_SYNC]   = ~rif.mask_top_one[SYNC_MASK_BIT];
  assign enabled[FLG_THERM]  = ~rif.mask_top_one[THERM_MASK_BIT];
  assign enabled[FLG_SAMPLE] = ~rif.mask_top_one[SAMPLE_MASK_BIT];
  assign enabled[FLG_REGRST] = ~rif.mask_top_two[REGRST_MASK_BIT];
  assign enabled[FLG_CONV]   = conv_rise_ok | conv_fall_ok;

  // Nothing is evaluated until the OTP defaults are in place.
  assign flag_set[FLG_PG]     = rif.masks_valid & power_good_event & enabled[FLG_PG];
  assign flag_set[FLG_SYNC]   = rif.masks_valid & sync_clk_event & enabled[FLG_SYNC];
  assign flag_set[FLG_THERM]  = rif.masks_valid & thermal_warning_event & enabled[FLG_THERM];
  assign flag_set[FLG_SAMPLE] = rif.masks_valid & current_sample_ready_event
                              & enabled[FLG_SAMPLE];
  assign flag_set[FLG_REGRST] = rif.masks_valid & reg_reset_event & enabled[FLG_REGRST];
  assign flag_set[FLG_CONV]   = rif.masks_valid
                              & ((conv_one_pg_rise_event & conv_rise_ok)
                              | (conv_one_pg_fall_event & conv_fall_ok));

  // A set in the same cycle as a clear wins.
  assign flag_next = flag_set | (flag_reg & ~flag_clear);
  assign irq_next  = |(flag_next & enabled);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flag_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      irq_reg  <= irq_next;
    end
  end

  assign flags      = flag_reg;
  assign irq_active = irq_reg;

endmodule : pmb_event_flags

// file: verilog/pmb_top.sv
// Top of the interrupt mask bank: serial port slave, mask registers, flags, status.
// Assumes scl and sda arrive asynchronously from the pins and that the pin pad
// pulls sda low while sda_oe is high; event and status inputs share this clock.
`timescale 1ns/1ps
module pmb_top
  import pmb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Serial port pins.
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // OTP mask defaults.
  input  wire logic [7:0]        otp_top_mask_one,
  input  wire logic [7:0]        otp_top_mask_two,
  input  wire logic [7:0]        otp_conv_mask,
  // Events.
  input  wire logic              power_good_event,
  input  wire logic              sync_clk_event,
  input  wire logic              thermal_warning_event,
  input  wire logic              current_sample_ready_event,
  input  wire logic              reg_reset_event,
  input  wire logic              conv_one_pg_rise_event,
  input  wire logic              conv_one_pg_fall_event,
  // Flag clears from the flag registers.
  input  wire logic [FLAG_W-1:0] flag_clear,
  // Raw conditions.
  input  wire logic              power_good_raw_in,
  input  wire logic              sync_clk_raw_in,
  input  wire logic              thermal_warning_raw_in,
  input  wire logic              conv_one_pg_raw_in,
  // Status views.
  output logic                   power_good_raw_state,
  output logic                   sync_clk_state,
  output logic                   thermal_warning_state,
  output logic                   conv_one_pg_state,
  // Flags and interrupt.
  output logic      [FLAG_W-1:0] irq_flags,
  output logic                   irq_active
);

  pmb_reg_if rif ();

  // Pin synchronisers; the third stage only serves edge detection.
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_last_reg;
  logic       sda_last_reg;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end

  wire scl_s      = scl_sync_reg[1];
  wire sda_s      = sda_sync_reg[1];
  wire scl_rise   = scl_s & ~scl_last_reg;
  wire scl_fall   = ~scl_s & scl_last_reg;
  wire start_det  = scl_s & scl_last_reg & sda_last_reg & ~sda_s;
  wire stop_det   = scl_s & scl_last_reg & ~sda_last_reg & sda_s;

  // Serial slave state.
  pmb_i2c_state_t state_reg;
  pmb_i2c_state_t state_next;
  logic [3:0]     bit_cnt_reg;
  logic [3:0]     bit_cnt_next;
  logic [7:0]     shift_reg;
  logic [7:0]     shift_next;
  logic [7:0]     ptr_reg;
  logic [7:0]     ptr_next;
  logic           rw_reg;
  logic           rw_next;
  logic           sda_oe_reg;
  logic           sda_oe_next;
  logic           wr_pulse;

  wire byte_done  = scl_fall & (bit_cnt_reg == BITS_PER_BYTE);
  wire addr_match = shift_reg[7:1] == DEV_ADDR;
  wire [7:0] shift_in  = {shift_reg[6:0], sda_s};
  wire [3:0] bit_cnt_inc = bit_cnt_reg + 4'h1;
  wire [7:0] ptr_inc     = ptr_reg + 8'h01;

  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    rw_next      = rw_reg;
    wr_pulse     = 1'b0;
    if (stop_det) begin
      state_next = ST_IDLE;
    end else if (start_det) begin
      state_next   = ST_ADDR;
      bit_cnt_next = BIT_CNT_RESET;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_ADDR, ST_PTR, ST_WR: begin
          if (scl_rise) begin
            shift_next   = shift_in;
            bit_cnt_next = bit_cnt_inc;
          end
          if (byte_done) begin
            bit_cnt_next = BIT_CNT_RESET;
            if (state_reg == ST_ADDR) begin
              rw_next    = shift_reg[0];
              state_next = addr_match ? ST_ADDR_ACK : ST_IDLE;
            end else if (state_reg == ST_PTR) begin
              ptr_next   = shift_reg;
              state_next = ST_PTR_ACK;
            end else begin
              wr_pulse   = 1'b1;
              state_next = ST_WR_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              shift_next = rif.rdata;
              state_next = ST_RD;
            end else begin
              state_next = ST_PTR;
            end
          end
        end
        ST_PTR_ACK: begin
          if (scl_fall) begin
            state_next = ST_WR;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            ptr_next   = ptr_inc;
            state_next = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt_reg == LAST_READ_BIT) begin
              bit_cnt_next = BIT_CNT_RESET;
              ptr_next     = ptr_inc;
              state_next   = ST_RD_ACK;
            end else begin
              shift_next   = {shift_reg[6:0], 1'b0};
              bit_cnt_next = bit_cnt_inc;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise && sda_s) begin
            state_next = ST_IDLE;
          end else if (scl_fall) begin
            shift_next = rif.rdata;
            state_next = ST_RD;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Pull sda low to acknowledge and to send zero bits of read data.
  always_comb begin
    case (state_next)
      ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK: begin
        sda_oe_next = 1'b1;
      end
      ST_RD: begin
        sda_oe_next = ~shift_next[7];
      end
      default: begin
        sda_oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= BIT_CNT_RESET;
      shift_reg   <= MASK_RESET;
      ptr_reg     <= PTR_RESET;
      rw_reg      <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      rw_reg      <= rw_next;
      sda_oe_reg  <= sda_oe_next;
    end
  end

  assign rif.wr_en = wr_pulse;
  assign rif.addr  = ptr_reg;
  assign rif.wdata = shift_reg;
  assign sda_out   = 1'b0;
  assign sda_oe    = sda_oe_reg;

  pmb_mask_regs pmb_mask_regs_i (
    .clock            (clock),
    .rst_b            (rst_b),
    .otp_top_mask_one (otp_top_mask_one),
    .otp_top_mask_two (otp_top_mask_two),
    .otp_conv_mask    (otp_conv_mask),
    .rif              (rif)
  );

  pmb_event_flags pmb_event_flags_i (
    .clock                      (clock),
    .rst_b                      (rst_b),
    .rif                        (rif),
    .power_good_event           (power_good_event),
    .sync_clk_event             (sync_clk_event),
    .thermal_warning_event      (thermal_warning_event),
    .current_sample_ready_event (current_sample_ready_event),
    .reg_reset_event            (reg_reset_event),
    .conv_one_pg_rise_event     (conv_one_pg_rise_event),
    .conv_one_pg_fall_event     (conv_one_pg_fall_event),
    .flag_clear                 (flag_clear),
    .flags                      (irq_flags),
    .irq_active                 (irq_active)
  );

  // Status views follow the raw conditions with no mask in the path.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      power_good_raw_state  <= 1'b0;
      sync_clk_state        <= 1'b0;
      thermal_warning_state <= 1'b0;
      conv_one_pg_state     <= 1'b0;
    end else begin
      power_good_raw_state  <= power_good_raw_in;
      sync_clk_state        <= sync_clk_raw_in;
      thermal_warning_state <= thermal_warning_raw_in;
      conv_one_pg_state     <= conv_one_pg_raw_in;
    end
  end

endmodule : pmb_top

// file: dv/pmb_top_asserts.sv
// Concurrent checks on the ports of the interrupt mask bank top.
// Assumes one clock domain and the synchronous active-low reset rst_b.
`timescale 1ns/1ps
module pmb_checker
  import pmb_pkg::*;
(
  // Clock and reset.
  input wire logic              clock,
  input wire logic              rst_b,
  // Serial data pin driver.
  input wire logic              sda_out,
  input wire logic              sda_oe,
  // Events, clears and raw conditions.
  input wire logic              power_good_event,
  input wire logic              sync_clk_event,
  input wire logic              thermal_warning_event,
  input wire logic              current_sample_ready_event,
  input wire logic              reg_reset_event,
  input wire logic              conv_one_pg_rise_event,
  input wire logic              conv_one_pg_fall_event,
  input wire logic [FLAG_W-1:0] flag_clear,
  input wire logic              power_good_raw_in,
  input wire logic              sync_clk_raw_in,
  input wire logic              thermal_warning_raw_in,
  input wire logic              conv_one_pg_raw_in,
  // Outputs under watch.
  input wire logic              power_good_raw_state,
  input wire logic              sync_clk_state,
  input wire logic              thermal_warning_state,
  input wire logic              conv_one_pg_state,
  input wire logic [FLAG_W-1:0] irq_flags,
  input wire logic              irq_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_b |=> (irq_flags == '0) && !irq_active && !sda_oe) else $error("reset not quiet");
  a_otp_first: assert property ($rose(rst_b) |=> irq_flags == '0)
    else $error("flag set before masks loaded");
  a_pg_cause: assert property ($rose(irq_flags[FLG_PG]) |-> $past(power_good_event))
    else $error("power good flag without event");
  a_sync_cause: assert property ($rose(irq_flags[FLG_SYNC]) |-> $past(sync_clk_event))
    else $error("sync flag without event");
  a_therm_cause: assert property (
    $rose(irq_flags[FLG_THERM]) |-> $past(thermal_warning_event)) else $error("thermal flag");
  a_sample_cause: assert property (
    $rose(irq_flags[FLG_SAMPLE]) |-> $past(current_sample_ready_event)) else $error("sample flag");
  a_regrst_cause: assert property (
    $rose(irq_flags[FLG_REGRST]) |-> $past(reg_reset_event)) else $error("reset flag");
  a_conv_cause: assert property ($rose(irq_flags[FLG_CONV]) |->
    $past(conv_one_pg_rise_event || conv_one_pg_fall_event)) else $error("converter flag");
  a_status_follow: assert property ($past(rst_b) |->
    {power_good_raw_state, sync_clk_state, thermal_warning_state, conv_one_pg_state} ==
    $past({power_good_raw_in, sync_clk_raw_in, thermal_warning_raw_in, conv_one_pg_raw_in}))
    else $error("status view does not follow raw input");
  a_irq_needs_flag: assert property (irq_active |-> irq_flags != '0)
    else $error("interrupt without flag");
  a_new_flag_irq: assert property (
    ($past(irq_flags) == '0) && (irq_flags != '0) |-> irq_active) else $error("irq missing");
  a_clear_drops: assert property (
    flag_clear[FLG_PG] && !power_good_event |=> !irq_flags[FLG_PG]) else $error("clear lost");
  a_open_drain: assert property (sda_out == 1'b0) else $error("sda driven high");

  c_irq: cover property ($rose(irq_active));
  c_ack: cover property ($rose(sda_oe));
  c_clear: cover property ($fell(irq_flags[FLG_CONV]));
endmodule : pmb_checker

bind pmb_top pmb_checker pmb_checker_i (.clock, .rst_b, .sda_out, .sda_oe, .power_good_event,
  .sync_clk_event, .thermal_warning_event, .current_sample_ready_event, .reg_reset_event,
  .conv_one_pg_rise_event, .conv_one_pg_fall_event, .flag_clear, .power_good_raw_in,
  .sync_clk_raw_in, .thermal_warning_raw_in, .conv_one_pg_raw_in, .power_good_raw_state,
  .sync_clk_state, .thermal_warning_state, .conv_one_pg_state, .irq_flags, .irq_active);

// file: dv/pmb_i2c_host.sv
// Host processor model on the serial port: start, stop, byte and register transfers.
// Assumes sda has a pull-up and the bench resolves the wire from all drivers.
`timescale 1ns/1ps
module pmb_i2c_host
  import pmb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
  input  wire logic clock,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  localparam int HALF = 20;

  // The serial clock stands high between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick();
    repeat (HALF) @(posedge clock);
  endtask : tick

  // Works from idle and as a repeated start with scl low.
  task automatic start();
    sda_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start

  task automatic stop();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b0;
    tick();
  endtask : stop

  // Data changes only half a phase after scl falls, never near the high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda_line;
    scl <= 1'b0;
    tick();
  endtask : bit_io

  task automatic send_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
  endtask : send_byte

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    start();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(ofs);
    send_byte(d);
    stop();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic r;
    start();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(ofs);
    start();
    send_byte({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop();
  endtask : read_reg
endmodule : pmb_i2c_host

// file: dv/pmb_interrupt_mask_bank_tb.sv
// Self-checking bench for the interrupt mask bank: registers, events, flags, status.
// Assumes the host model on the serial port and a 100 MHz clock.
`timescale 1ns/1ps
module pmic_interrupt_mask_bank_tb
  import pmb_pkg::*;
;
  logic              clock;
  logic              rst_b;
  logic              scl;
  logic              sda_low;
  logic              sda_out;
  logic              sda_oe;
  logic              irq_active;
  logic [7:0]        otp1;
  logic [7:0]        otp2;
  logic [7:0]        otpc;
  logic [6:0]        ev;
  logic [3:0]        raw;
  logic [3:0]        states;
  logic [FLAG_W-1:0] flag_clear;
  logic [FLAG_W-1:0] irq_flags;
  wire logic         sda_line = ~(sda_low | sda_oe);
  int                fails;
  int                tests_run;
  // Events: pg, sync, thermal, sample, register reset, conv rise, conv fall.
  localparam int FLAG_OF [7] = '{0, 1, 2, 3, 4, 5, 5};

  pmb_top pmb_top_i (.clock(clock), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .otp_top_mask_one(otp1), .otp_top_mask_two(otp2),
    .otp_conv_mask(otpc), .power_good_event(ev[0]), .sync_clk_event(ev[1]),
    .thermal_warning_event(ev[2]), .current_sample_ready_event(ev[3]),
    .reg_reset_event(ev[4]), .conv_one_pg_rise_event(ev[5]), .conv_one_pg_fall_event(ev[6]),
    .flag_clear(flag_clear), .power_good_raw_in(raw[3]), .sync_clk_raw_in(raw[2]),
    .thermal_warning_raw_in(raw[1]), .conv_one_pg_raw_in(raw[0]),
    .power_good_raw_state(states[3]), .sync_clk_state(states[2]),
    .thermal_warning_state(states[1]), .conv_one_pg_state(states[0]),
    .irq_flags(irq_flags), .irq_active(irq_active));

  pmb_i2c_host pmb_i2c_host_i (.clock(clock), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : check

  task automatic do_reset(input logic [7:0] two);
    @(posedge clock);
    otp2 <= two;
    rst_b <= 1'b0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : do_reset

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    pmb_i2c_host_i.read_reg(ofs, d);
    check(d, exp);
  endtask : rd_chk

  // Raises one event for one cycle and returns once its flag has landed.
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev <= '0;
    #1;
  endtask : pulse

  task automatic clear_all();
    @(posedge clock);
    flag_clear <= '1;
    @(posedge clock);
    flag_clear <= '0;
    #1;
    check({1'b0, irq_active, irq_flags}, 8'h00);
  endtask : clear_all

  task automatic t_regs();
    do_reset(8'h00);
    rd_chk(TOP_MASK_ONE_OFS, otp1 & TOP_ONE_OTP_FIELDS);
    rd_chk(TOP_MASK_TWO_OFS, 8'h00);
    rd_chk(CONV_MASK_OFS, otpc & CONV_OTP_FIELDS);
    rd_chk(8'h30, READ_UNMAPPED);
    pmb_i2c_host_i.write_reg(TOP_MASK_TWO_OFS, 8'hFF);
    rd_chk(TOP_MASK_TWO_OFS, 8'hFE);
    do_reset(8'h01);
    pulse(4);
    check({2'b00, irq_flags}, 8'h00);
    pmb_i2c_host_i.write_reg(TOP_MASK_TWO_OFS, 8'h00);
    pulse(4);
    check({2'b00, irq_flags}, 8'h00);
  endtask : t_regs

  task automatic t_events();
    do_reset(8'h00);
    pmb_i2c_host_i.write_reg(TOP_MASK_ONE_OFS, 8'h00);
    pmb_i2c_host_i.write_reg(CONV_MASK_OFS, 8'h00);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      check({1'b0, irq_active, irq_flags}, 8'h40 | (8'h01 << FLAG_OF[i]));
      clear_all();
    end
    pmb_i2c_host_i.write_reg(TOP_MASK_ONE_OFS, 8'hFF);
    pmb_i2c_host_i.write_reg(CONV_MASK_OFS, 8'hFF);
    @(posedge clock);
    raw <= 4'hF;
    for (int i = 0; i < 7; i++) begin
      if (i != 4) begin
        pulse(i);
        check({1'b0, irq_active, irq_flags}, 8'h00);
      end
    end
    check({4'h0, states}, 8'h0F);
    pmb_i2c_host_i.write_reg(CONV_MASK_OFS, 8'h80);
    pulse(6);
    check({2'b00, irq_flags}, 8'h00);
    pulse(5);
    check({1'b0, irq_active, irq_flags}, 8'h60);
    clear_all();
    pmb_i2c_host_i.write_reg(TOP_MASK_ONE_OFS, 8'h00);
    pulse(0);
    pmb_i2c_host_i.write_reg(TOP_MASK_ONE_OFS, 8'h80);
    check({1'b0, irq_active, irq_flags}, 8'h01);
    clear_all();
  endtask : t_events

  initial begin
    rst_b = 1'b0;
    otp1 = 8'hFF;
    otp2 = 8'h00;
    otpc = 8'hFF;
    ev = '0;
    raw = 4'h0;
    flag_clear = '0;
    fails = 0;
    tests_run = 0;
    t_regs();
    t_events();
    test_done();
  end

  // Both scenarios need about 27800 cycles; the limit leaves ample margin.
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    test_done();
  end
endmodule : pmic_interrupt_mask_bank_tb
